// ==== design/uabw_core.sv ====
// Rate measurement and wake-on-break logic of an asynchronous receiver
//
// Behaviour
// - Rate detection times a 0x55 sync character over its five rising edges.
// - Setting measure enable starts calibration; receiver held idle meanwhile.
// - Counting begins at first rising edge after the start bit.
// - Fifth rising edge stores count in divisor pair, clears enable, sets flag.
// - Reading receive data clears flag from a finished measurement.
// - Both divisor registers form one 16-bit counter during measurement.
// - Measurement clock is Fosc/512, Fosc/128 or Fosc/32 by select bits.
// - Counter starts at one; software subtracts one afterwards.
// - Overflow flag sets when the counter wraps before the fifth edge.
// - After overflow counting continues; fifth edge finishes as usual.
// - Overflow flag cleared by direct write, not by data read.
// - Overflow flag stays set if cleared while enable is still one.
// - With wake and measure both set, measure the character after break.
// - Wake detection only in asynchronous mode; like all logic, it needs clock enable high.
// - While wake enabled in asynchronous mode, normal reception is off and receiver idles.
// - A falling receive line transition is the wake event.
// - Receive flag sets with the wake event; data read clears it.
// - Rising transition ending the break clears wake enable.
// - Nonzero character when armed: its first low time is the wake event.
`timescale 1ns/1ps

module uabw_core (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       clkEn,
    input  wire logic       rxLine,
    input  wire logic       regWr,
    input  wire logic       regRd,
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    output logic            receiveFlag,
    output logic            rxIdle,
    output logic            wakeEvent
);

    ////////////////////////////////////////////////////////////////////////
    // State
    uabw_pkg::uabw_state_t state_r;
    uabw_pkg::uabw_state_t state_nxt;
    logic        measEn_r;
    logic        ovf_r;
    logic        wakeEn_r;
    logic        wideSel_r;
    logic        highSel_r;
    logic        asyncMode_r;
    logic [15:0] div_r;
    logic [8:0]  pre_r;
    logic [2:0]  edges_r;
    logic        rxPrev_r;
    logic        rxFlag_r;
    logic [7:0]  rdata_r;
    logic        idle_r;
    logic        wakePulse_r;
    uabw_pkg::uabw_req_t req;

    assign req = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};

    ////////////////////////////////////////////////////////////////////////
    // Decoding
    wire wrCtrl  = req.wr && (req.addr == uabw_pkg::ADDR_CTRL);
    wire wrDivLo = req.wr && (req.addr == uabw_pkg::ADDR_DIV_LO);
    wire wrDivHi = req.wr && (req.addr == uabw_pkg::ADDR_DIV_HI);
    wire rdData  = req.rd && (req.addr == uabw_pkg::ADDR_RXDATA);

    wire rise = rxLine && !rxPrev_r;
    wire fall = !rxLine && rxPrev_r;

    // Prescaler reload chosen from the two select bits
    wire [8:0] preLoad =
        ({wideSel_r, highSel_r} == 2'b00) ? uabw_pkg::PRE_SLOW :
        ({wideSel_r, highSel_r} == 2'b11) ? uabw_pkg::PRE_FAST :
                                             uabw_pkg::PRE_MID;
    wire measTick = (pre_r == 9'h000);

    // Wake armed only in asynchronous mode
    wire wakeArmed  = wakeEn_r && asyncMode_r;
    // Measurement waits while the break is still in progress
    wire measActive = measEn_r && !wakeArmed;

    wire inCount   = (state_r == uabw_pkg::MS_COUNT);
    // The first rise is taken in the start state, so only four more count
    wire lastEdge  = inCount && rise &&
                     (edges_r == uabw_pkg::SYNC_EDGES - 3'h2);
    wire wrapNow   = inCount && measTick && (div_r == 16'hFFFF);
    wire wakeFall  = wakeArmed && fall && (state_r == uabw_pkg::MS_IDLE);
    wire wakeRise  = (state_r == uabw_pkg::MS_WAKE) && rise;

    ////////////////////////////////////////////////////////////////////////
    // State machine
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            uabw_pkg::MS_IDLE: begin
                if (wakeFall) begin
                    state_nxt = uabw_pkg::MS_WAKE;
                end else if (measActive && fall) begin
                    state_nxt = uabw_pkg::MS_START;
                end
            end
            uabw_pkg::MS_START: begin
                // Start bit done; counting opens at the first rise
                if (!measEn_r) begin
                    state_nxt = uabw_pkg::MS_IDLE;
                end else if (rise) begin
                    state_nxt = uabw_pkg::MS_COUNT;
                end
            end
            uabw_pkg::MS_COUNT: begin
                if (!measEn_r || lastEdge) begin
                    state_nxt = uabw_pkg::MS_IDLE;
                end
            end
            uabw_pkg::MS_WAKE: begin
                // Any first rise ends the wake, break or not
                if (rise) begin
                    state_nxt = uabw_pkg::MS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= uabw_pkg::MS_IDLE;
        end else if (clkEn) begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sampling and measurement counting
    always_ff @(posedge clk) begin
        if (reset) begin
            rxPrev_r <= 1'b1;
            pre_r    <= 9'h000;
            edges_r  <= 3'h0;
        end else if (clkEn) begin
            rxPrev_r <= rxLine;
            if (state_r != uabw_pkg::MS_COUNT) begin
                pre_r   <= preLoad;
                edges_r <= 3'h0;
            end else begin
                pre_r <= measTick ? preLoad : pre_r - 9'h001;
                if (rise) begin
                    edges_r <= edges_r + 3'h1;
                end
            end
        end
    end

    // Divisor pair: software writes it; measurement uses it as a counter
    always_ff @(posedge clk) begin
        if (reset) begin
            div_r <= uabw_pkg::DIV_RESET;
        end else if (clkEn) begin
            if (state_r == uabw_pkg::MS_START && rise) begin
                div_r <= uabw_pkg::COUNT_START;
            end else if (inCount) begin
                if (measTick) begin
                    div_r <= div_r + 16'h0001;
                end
            end else if (wrDivLo) begin
                div_r[7:0] <= req.wdata;
            end else if (wrDivHi) begin
                div_r[15:8] <= req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control bits
    always_ff @(posedge clk) begin
        if (reset) begin
            measEn_r    <= uabw_pkg::CTRL_RESET[uabw_pkg::BIT_MEAS_EN];
            ovf_r       <= uabw_pkg::CTRL_RESET[uabw_pkg::BIT_OVF];
            wakeEn_r    <= uabw_pkg::CTRL_RESET[uabw_pkg::BIT_WAKE_EN];
            wideSel_r   <= uabw_pkg::CTRL_RESET[uabw_pkg::BIT_WIDE_SEL];
            highSel_r   <= uabw_pkg::CTRL_RESET[uabw_pkg::BIT_HIGH_SEL];
            asyncMode_r <= uabw_pkg::CTRL_RESET[uabw_pkg::BIT_ASYNC];
        end else if (clkEn) begin
            if (wrCtrl) begin
                wideSel_r   <= req.wdata[uabw_pkg::BIT_WIDE_SEL];
                highSel_r   <= req.wdata[uabw_pkg::BIT_HIGH_SEL];
                asyncMode_r <= req.wdata[uabw_pkg::BIT_ASYNC];
            end
            // Hardware clear at the final edge wins over a write
            if (lastEdge) begin
                measEn_r <= 1'b0;
            end else if (wrCtrl) begin
                measEn_r <= req.wdata[uabw_pkg::BIT_MEAS_EN];
            end
            // Set wins over clear; clear refused while enable still one
            if (wrapNow) begin
                ovf_r <= 1'b1;
            end else if (wrCtrl && !req.wdata[uabw_pkg::BIT_OVF] &&
                         !measEn_r) begin
                ovf_r <= 1'b0;
            end
            if (wakeRise) begin
                wakeEn_r <= 1'b0;
            end else if (wrCtrl) begin
                wakeEn_r <= req.wdata[uabw_pkg::BIT_WAKE_EN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive flag, read data, outputs
    wire flagSet = lastEdge || wakeFall;

    wire [7:0] ctrlView = {2'b00, asyncMode_r, highSel_r, wideSel_r,
                           wakeEn_r, ovf_r, measEn_r};
    wire [7:0] statView = {6'h00, !idle_r, rxFlag_r};
    wire [7:0] rdMux =
        (req.addr == uabw_pkg::ADDR_CTRL)   ? ctrlView     :
        (req.addr == uabw_pkg::ADDR_DIV_LO) ? div_r[7:0]   :
        (req.addr == uabw_pkg::ADDR_DIV_HI) ? div_r[15:8]  :
        (req.addr == uabw_pkg::ADDR_STATUS) ? statView     :
                                              8'h00;

    always_ff @(posedge clk) begin
        if (reset) begin
            rxFlag_r    <= 1'b0;
            rdata_r     <= 8'h00;
            idle_r      <= 1'b1;
            wakePulse_r <= 1'b0;
        end else if (clkEn) begin
            // Set wins over a same-cycle data read
            if (flagSet) begin
                rxFlag_r <= 1'b1;
            end else if (rdData) begin
                rxFlag_r <= 1'b0;
            end
            rdata_r <= req.rd ? rdMux : 8'h00;
            // Receiver held idle during measuring or armed wake
            idle_r      <= !(measEn_r || wakeArmed);
            wakePulse_r <= wakeFall;
        end
    end

    assign regRdata    = rdata_r;
    assign receiveFlag = rxFlag_r;
    assign rxIdle      = idle_r;
    assign wakeEvent   = wakePulse_r;

endmodule

// ==== shared/uabw_pkg.sv ====
// Package: constants and carrier types for the rate measurement and wake block
package uabw_pkg;

    // Register indices on the plain register port
    localparam logic [2:0] ADDR_CTRL    = 3'h0;
    localparam logic [2:0] ADDR_DIV_LO  = 3'h1;
    localparam logic [2:0] ADDR_DIV_HI  = 3'h2;
    localparam logic [2:0] ADDR_RXDATA  = 3'h3;
    localparam logic [2:0] ADDR_STATUS  = 3'h4;

    // Control register field positions
    localparam int BIT_MEAS_EN   = 0;
    localparam int BIT_OVF       = 1;
    localparam int BIT_WAKE_EN   = 2;
    localparam int BIT_WIDE_SEL  = 3;
    localparam int BIT_HIGH_SEL  = 4;
    localparam int BIT_ASYNC     = 5;

    // Status register field positions
    localparam int BIT_RX_FLAG   = 0;
    localparam int BIT_BUSY      = 1;

    // Reset values
    localparam logic [7:0]  CTRL_RESET = 8'h20;
    localparam logic [15:0] DIV_RESET  = 16'h0000;
    localparam logic [15:0] COUNT_START = 16'h0001;

    // Measurement clock dividers in system clocks
    localparam int DIV_SLOW = 512;
    localparam int DIV_MID  = 128;
    localparam int DIV_FAST = 32;
    localparam logic [8:0] PRE_SLOW = 9'(DIV_SLOW - 1);
    localparam logic [8:0] PRE_MID  = 9'(DIV_MID - 1);
    localparam logic [8:0] PRE_FAST = 9'(DIV_FAST - 1);

    // Rising edges in one sync character
    localparam logic [2:0] SYNC_EDGES = 3'h5;

    typedef enum logic [3:0] {
        MS_IDLE  = 4'b0001,
        MS_START = 4'b0010,
        MS_COUNT = 4'b0100,
        MS_WAKE  = 4'b1000
    } uabw_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } uabw_req_t;

endpackage

// ==== testbench/uabw_assertions.sv ====
// Port checker of the rate measurement and wake block
`timescale 1ns/1ps
module uabw_assertions (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       clkEn,
    input wire logic       rxLine,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic       receiveFlag,
    input wire logic       rxIdle,
    input wire logic       wakeEvent
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic rdData = regRd && clkEn && regAddr == uabw_pkg::ADDR_RXDATA;
    wire logic wrCtrl = regWr && clkEn && regAddr == uabw_pkg::ADDR_CTRL;
    wire logic wakeW  = regWdata[uabw_pkg::BIT_WAKE_EN]
        && regWdata[uabw_pkg::BIT_ASYNC];
    ////////////////////////////////////////////////////////////////////////
    chk_read_stands: assert property (
        $past(clkEn) && !$past(regRd) |-> regRdata == 8'h00)
        else $error("read data outside its cycle");
    // A set landing with the read wins; the bench never lets them meet
    chk_flag_clear: assert property (rdData |=> !receiveFlag)
        else $error("flag kept after data read");
    chk_flag_holds: assert property (
        receiveFlag && clkEn && !rdData |=> receiveFlag)
        else $error("flag lost without read");
    chk_flag_cause: assert property (
        $rose(receiveFlag) |-> !$past(rxIdle))
        else $error("flag set while receiver idle");
    chk_wake_pulse: assert property (
        wakeEvent && clkEn |-> receiveFlag ##1 !wakeEvent)
        else $error("wake pulse malformed");
    chk_wake_fall: assert property (
        $rose(wakeEvent) |-> !$past(rxLine) && !rxLine)
        else $error("wake without low line");
    chk_idle_measure: assert property (
        wrCtrl && regWdata[uabw_pkg::BIT_MEAS_EN] |-> ##[1:3] !rxIdle)
        else $error("receiver not held during measure");
    chk_idle_wake: assert property (
        wrCtrl && wakeW |-> ##[1:3] !rxIdle)
        else $error("receiver not held while wake armed");
    cover property (wakeEvent);
    cover property ($rose(receiveFlag));
    cover property (rdData && receiveFlag);
endmodule
bind uabw_core uabw_assertions i_chk (.clk(clk), .reset(reset), .clkEn(clkEn),
    .rxLine(rxLine), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .receiveFlag(receiveFlag),
    .rxIdle(rxIdle), .wakeEvent(wakeEvent));

// ==== testbench/uabw_node.sv ====
// Remote serial node that drives the receive line
`timescale 1ns/1ps
module uabw_node (
    input  wire logic clk,
    output logic      rxLine
);
    initial rxLine = 1'b1;
    // Each level is held n whole clocks from the edge that sets it
    task automatic hold(input logic v, input int n);
        @(posedge clk);
        rxLine <= v;
        repeat (n - 1) @(posedge clk);
    endtask
    task automatic sendByte(input logic [7:0] b, input int t);
        hold(1'b0, t);
        for (int i = 0; i < 8; i++) hold(b[i], t);
        hold(1'b1, t);
    endtask
    // A long high gap lets the receiver settle before the next character
    task automatic sendBreak(input int bits, input int t);
        hold(1'b0, bits * t);
        hold(1'b1, 4 * t);
    endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench of the rate measurement and wake block
`timescale 1ns/1ps
module tb;
    // Bit time chosen off every divider boundary so counts are unambiguous
    localparam int BT = 102;
    localparam logic [2:0] CT = uabw_pkg::ADDR_CTRL;
    localparam logic [2:0] RX = uabw_pkg::ADDR_RXDATA;
    localparam logic [2:0] ST = uabw_pkg::ADDR_STATUS;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       clkEn = 1'b1;
    logic       regWr = 1'b0;
    logic       regRd = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata;
    logic       receiveFlag, rxIdle, wakeEvent, rxLine;
    int         err_total = 0, checks_done = 0, wakeCnt = 0;
`define CHECK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    err_total++; $display("[FAIL] %0t got %h want %h", $time, a, e); end end
    always #10 clk = ~clk;
    always @(posedge clk) if (wakeEvent === 1'b1) wakeCnt <= wakeCnt + 1;
    uabw_core i_dut (.clk(clk), .reset(reset), .clkEn(clkEn), .rxLine(rxLine),
        .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .receiveFlag(receiveFlag), .rxIdle(rxIdle),
        .wakeEvent(wakeEvent));
    uabw_node i_node (.clk(clk), .rxLine(rxLine));
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        `CHECK(regRdata, e)
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic scnMeasure(input logic [1:0] sel);
        logic [7:0]  c;
        logic [15:0] e;
        c = {3'h1, sel[1], sel[0], 3'h0};
        e = 16'(1 + 8 * BT / (sel == 2'h0 ? uabw_pkg::DIV_SLOW :
            sel == 2'h3 ? uabw_pkg::DIV_FAST : uabw_pkg::DIV_MID));
        wr(CT, c | 8'h01);
        repeat (4) @(posedge clk);
        `CHECK(rxIdle, 1'b0)
        i_node.sendByte(8'h55, BT);
        chk(CT, c);
        chk(uabw_pkg::ADDR_DIV_LO, e[7:0]);
        chk(uabw_pkg::ADDR_DIV_HI, e[15:8]);
        chk(RX, 8'h00);
        `CHECK(receiveFlag, 1'b0)
        chk(CT, c);
    endtask
    // A write while the clock enable is low must not land
    task automatic scnFreeze;
        @(posedge clk);
        clkEn <= 1'b0;
        wr(CT, 8'h21);
        @(posedge clk);
        clkEn <= 1'b1;
        chk(CT, uabw_pkg::CTRL_RESET);
        `CHECK(rxIdle, 1'b1)
    endtask
    task automatic scnWake;
        wr(CT, 8'h3D);
        repeat (4) @(posedge clk);
        `CHECK(rxIdle, 1'b0)
        i_node.sendBreak(13, BT);
        `CHECK(wakeCnt, 1)
        `CHECK(receiveFlag, 1'b1)
        chk(CT, 8'h39);
        chk(RX, 8'h00);
        `CHECK(receiveFlag, 1'b0)
        i_node.sendByte(8'h55, BT);
        chk(uabw_pkg::ADDR_DIV_LO, 8'(1 + 8 * BT / uabw_pkg::DIV_FAST));
        chk(RX, 8'h00);
    endtask
    task automatic scnArmedData;
        wr(CT, 8'h04);
        i_node.sendBreak(13, BT);
        `CHECK(wakeCnt, 1)
        chk(ST, 8'h00);
        wr(CT, 8'h24);
        i_node.sendByte(8'h55, BT);
        `CHECK(wakeCnt, 2)
        chk(CT, 8'h20);
        chk(RX, 8'h00);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        chk(CT, uabw_pkg::CTRL_RESET);
        chk(ST, 8'h00);
        chk(3'h7, 8'h00);
        scnFreeze();
        for (int s = 0; s < 4; s++) scnMeasure(2'(s));
        scnWake();
        scnArmedData();
        results();
    end
endmodule
